// ---- rtl/dpc_pkg.sv ----
// Package for the dual-loop divider configuration register bank
`default_nettype none
package dpc_pkg;
   localparam logic [4:0]  REG_FIRST_PUMP_REF   = 5'h1b;
   localparam logic [4:0]  REG_SECOND_REF_FB    = 5'h1c;
   localparam logic [4:0]  REG_OSC_RANGE_CAL    = 5'h1d;
   localparam logic [4:0]  REG_SECOND_FB        = 5'h1e;
   localparam logic [4:0]  REG_READBACK_CTRL    = 5'h1f;
   localparam logic [4:0]  REG_READBACK_ECHO    = 5'h0c;
   localparam logic [4:0]  RB_RESERVED_A        = 5'h09;
   localparam logic [4:0]  RB_RESERVED_LO       = 5'h10;
   localparam logic [4:0]  RB_RESERVED_HI       = 5'h17;
   // Field positions (lsb)
   localparam int POS_PUMP_POL     = 28;
   localparam int POS_PRE_DIV2     = 24;
   localparam int POS_PRE_DIV1     = 22;
   localparam int POS_PRE_DIV0     = 20;
   localparam int POS_FIRST_REF    = 6;
   localparam int POS_PUMP_HIZ     = 5;
   localparam int POS_SECOND_REF   = 20;
   localparam int POS_FIRST_FB     = 6;
   localparam int POS_OSC_RANGE    = 24;
   localparam int POS_FAST_DET     = 23;
   localparam int POS_CAL_FB       = 5;
   localparam int POS_PRESCALER    = 24;
   localparam int POS_SECOND_FB    = 5;
   localparam int POS_RB_LEVEL     = 21;
   localparam int POS_RB_ADDR      = 16;
   localparam int POS_WRITE_LOCK   = 5;
   localparam int POS_ECHO_ADDR    = 16;
   // Widths
   localparam int W_FIRST_REF  = 14;
   localparam int W_SECOND_REF = 12;
   localparam int W_FIRST_FB   = 14;
   localparam int W_SECOND_FB  = 18;
   localparam int W_RB_ADDR    = 5;
   // Reset values
   localparam logic [31:0] RST_FIRST_PUMP_REF = 32'h0000_0040;
   localparam logic [31:0] RST_SECOND_REF_FB  = 32'h0010_0040;
   localparam logic [31:0] RST_OSC_RANGE_CAL  = 32'h0000_0020;
   localparam logic [31:0] RST_SECOND_FB      = 32'h0000_0020;
   localparam logic [31:0] RST_READBACK_CTRL  = 32'h0000_0000;
   // Calibration length in clock cycles (short stand-in)
   localparam int CAL_CYCLES_DEF = 64;
   // Pump current codes in microamps
   localparam logic [10:0] PUMP_UA_0 = 11'h064;
   localparam logic [10:0] PUMP_UA_1 = 11'h0c8;
   localparam logic [10:0] PUMP_UA_2 = 11'h190;
   localparam logic [10:0] PUMP_UA_3 = 11'h640;
   // Oscillator range codes
   localparam logic [2:0]  OSC_RANGE_RESERVED = 3'h3;
   localparam logic [2:0]  OSC_RANGE_MAX      = 3'h4;

   typedef enum logic [1:0] {
      DPC_IDLE  = 2'b00,
      DPC_SYNC  = 2'b01,
      DPC_CAL   = 2'b11
   } dpc_cal_e;

   // Pre-divider code to ratio 1,2,4,8
   function automatic logic [3:0] dpc_pow2(input logic [1:0] code);
      dpc_pow2 = 4'h1 << code;
   endfunction : dpc_pow2
endpackage : dpc_pkg
`default_nettype wire

// ---- rtl/dpc_cal_seq.sv ----
// Calibration sequencer: sync pulse then timed calibration window
`default_nettype none
module dpc_cal_seq
   import dpc_pkg::*;
#(
   parameter int CAL_CYCLES = CAL_CYCLES_DEF
) (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic start,
   output logic      cal_busy,
   output logic      sync_pulse
);
   if (CAL_CYCLES < 2 || CAL_CYCLES > 65535) begin : g_bad_cal
      $error("CAL_CYCLES out of range");
   end

   dpc_cal_e    state_q;
   logic [15:0] cnt_q;

   // RULE12: start calibration on write
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= DPC_IDLE;
         cnt_q   <= 16'h0000;
      end else begin
         unique case (state_q)
            DPC_IDLE: begin
               if (start) begin
                  state_q <= DPC_SYNC;
               end
            end
            DPC_SYNC: begin
               cnt_q   <= 16'(CAL_CYCLES - 1);
               // Back-to-back writes: sync holds while start stays high, giving one longer pulse
               if (!start) begin
                  state_q <= DPC_CAL;
               end
            end
            DPC_CAL: begin
               // A fresh write restarts the run
               if (start) begin
                  state_q <= DPC_SYNC;
               end else if (cnt_q == 16'h0000) begin
                  state_q <= DPC_IDLE;
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            default: state_q <= DPC_IDLE;
         endcase
      end
   end

   // RULE13: sync with each run
   assign sync_pulse = (state_q == DPC_SYNC);
   assign cal_busy   = (state_q != DPC_IDLE);

   a_sync_after_start: assert property (@(posedge clk) disable iff (reset) // RULE13
      start |=> sync_pulse) else $error("no sync after start");
   a_busy_after_sync: assert property (@(posedge clk) disable iff (reset) // RULE12
      sync_pulse |=> cal_busy [*2]) else $error("calibration did not run");
endmodule : dpc_cal_seq
`default_nettype wire

// ---- rtl/dpc_regs.sv ----
// Register bank for the two cascaded loops' divider configuration
//
// Functional notes
// RULE1: polarity bit 0 negative, 1 positive slope
// RULE2: current codes give 100/200/400/1600 uA
// RULE3: hi-z bit set floats the pump
// RULE4: three 2-bit pre-dividers, ratios 1..8
// RULE5: active input's pre-divider feeds reference divider
// RULE6: first reference divider 14 bits, zero reserved
// RULE7: second reference divider 12 bits, zero invalid
// RULE8: host enables doubler when ratio is one
// RULE9: first feedback divider zero is invalid
// RULE10: 3-bit oscillator range feeds calibration
// RULE11: host sets fast detector above 100 MHz
// RULE12: register 30 write starts VCO calibration
// RULE13: each calibration issues a sync event
// RULE14: calibration uses calibration feedback divider
// RULE15: prescaler 0 is 8, 1-2 are 2
// RULE16: second feedback divider 18 bits, zero invalid
// RULE17: readback level sets latch pin level
// RULE18: readback address selects register, some reserved
// RULE19: register 12 readback shows readback address
// RULE20: host ignores upper bits of register 31
// RULE21: write lock refuses writes to 0..30
// RULE22: invalid codes stored, flagged, otherwise harmless
`default_nettype none
module dpc_regs
   import dpc_pkg::*;
#(
   parameter int CAL_CYCLES = CAL_CYCLES_DEF
) (
   input  wire logic        clk,
   input  wire logic        reset,
   // Serial interface after deframing
   input  wire logic        wr_strobe,
   input  wire logic [4:0]  wr_addr,
   input  wire logic [31:0] wr_data,
   input  wire logic [31:0] echo_reg_in,
   input  wire logic [31:0] other_reg_in,
   output logic [31:0]      rd_data,
   output logic [4:0]       rd_addr,
   output logic             rd_valid,
   output logic             rb_latch_level,
   // Loop controls
   input  wire logic [1:0]  active_input,
   input  wire logic        internal_vco_mode,
   output logic             first_loop_pump_polarity,
   output logic [10:0]      first_loop_pump_ua,
   output logic             first_loop_pump_output_en,
   output logic [3:0]       input_pre_ratio,
   output logic [13:0]      first_loop_ref_divider,
   output logic [11:0]      second_loop_ref_divider,
   output logic [13:0]      first_loop_feedback_divider,
   output logic [2:0]       osc_input_freq_range,
   output logic             second_loop_fast_detector,
   output logic [3:0]       second_loop_prescale_ratio,
   output logic [17:0]      second_loop_active_feedback,
   output logic             register_write_lock,
   output logic             cal_busy,
   output logic             sync_event,
   output logic             config_invalid
);
   if (CAL_CYCLES < 2) begin : g_bad_cal
      $error("CAL_CYCLES too small");
   end

   // Every check below runs on the bank clock
   default clocking cb_bank @(posedge clk);
   endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   logic [31:0] pump_ref_q;
   logic [31:0] ref_fb_q;
   logic [31:0] osc_cal_q;
   logic [31:0] second_fb_q;
   logic [31:0] rb_ctrl_q;
   logic        lock_q;
   logic        wr_ok;
   logic        cal_start;

   // RULE21: lock gates writes below 31
   assign wr_ok = wr_strobe && (!lock_q || wr_addr == REG_READBACK_CTRL);

   // RULE22: any code is stored as written
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pump_ref_q  <= RST_FIRST_PUMP_REF;
         ref_fb_q    <= RST_SECOND_REF_FB;
         osc_cal_q   <= RST_OSC_RANGE_CAL;
         second_fb_q <= RST_SECOND_FB;
      end else if (wr_ok) begin
         unique case (wr_addr)
            REG_FIRST_PUMP_REF: pump_ref_q  <= wr_data;
            REG_SECOND_REF_FB:  ref_fb_q    <= wr_data;
            REG_OSC_RANGE_CAL:  osc_cal_q   <= wr_data;
            REG_SECOND_FB:      second_fb_q <= wr_data;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rb_ctrl_q <= RST_READBACK_CTRL;
         lock_q    <= 1'b0;
      end else if (wr_strobe && wr_addr == REG_READBACK_CTRL) begin
         rb_ctrl_q <= wr_data;
         lock_q    <= wr_data[POS_WRITE_LOCK];
      end
   end
   assign register_write_lock = lock_q;

   ////////////////////////////////////////////////////////////////////////////
   // Decoded controls
   logic [1:0] pump_code;
   logic [1:0] pre_code;
   assign pump_code = pump_ref_q[27:26];

   // RULE1: polarity straight from bit
   assign first_loop_pump_polarity = pump_ref_q[POS_PUMP_POL];

   // RULE2: current code mapping
   always_comb begin
      unique case (pump_code)
         2'h0: first_loop_pump_ua = PUMP_UA_0;
         2'h1: first_loop_pump_ua = PUMP_UA_1;
         2'h2: first_loop_pump_ua = PUMP_UA_2;
         2'h3: first_loop_pump_ua = PUMP_UA_3;
      endcase
   end

   // RULE3: hi-z overrides current code
   assign first_loop_pump_output_en = !pump_ref_q[POS_PUMP_HIZ];

   // RULE5: active input picks pre-divider
   always_comb begin
      unique case (active_input)
         2'h2:    pre_code = pump_ref_q[POS_PRE_DIV2 +: 2];
         2'h1:    pre_code = pump_ref_q[POS_PRE_DIV1 +: 2];
         default: pre_code = pump_ref_q[POS_PRE_DIV0 +: 2];
      endcase
   end
   // RULE4: ratio is two to the code
   assign input_pre_ratio = dpc_pow2(pre_code);

   // RULE6: 14-bit first reference divider
   assign first_loop_ref_divider      = pump_ref_q[POS_FIRST_REF +: W_FIRST_REF];
   // RULE7: 12-bit second reference divider
   assign second_loop_ref_divider     = ref_fb_q[POS_SECOND_REF +: W_SECOND_REF];
   // RULE9: first feedback divider field
   assign first_loop_feedback_divider = ref_fb_q[POS_FIRST_FB +: W_FIRST_FB];
   // RULE10: range code to calibration
   assign osc_input_freq_range        = osc_cal_q[POS_OSC_RANGE +: 3];
   assign second_loop_fast_detector   = osc_cal_q[POS_FAST_DET];

   // RULE15: prescaler ratio mapping
   always_comb begin
      unique case (second_fb_q[POS_PRESCALER +: 3])
         3'h0:       second_loop_prescale_ratio = 4'h8;
         3'h1, 3'h2: second_loop_prescale_ratio = 4'h2;
         default:    second_loop_prescale_ratio = {1'b0, second_fb_q[POS_PRESCALER +: 3]};
      endcase
   end

   // RULE6: flag zero dividers as invalid
   // RULE16: second feedback zero is invalid
   assign config_invalid = (first_loop_ref_divider == 14'h0000)
                        || (second_loop_ref_divider == 12'h000)
                        || (first_loop_feedback_divider == 14'h0000)
                        || (second_fb_q[POS_SECOND_FB +: W_SECOND_FB] == 18'h00000)
                        || (osc_cal_q[POS_CAL_FB +: W_SECOND_FB] == 18'h00000)
                        || (osc_input_freq_range == OSC_RANGE_RESERVED)
                        || (osc_input_freq_range > OSC_RANGE_MAX);

   ////////////////////////////////////////////////////////////////////////////
   // Calibration
   // RULE12: register 30 write in VCO mode
   assign cal_start = wr_ok && wr_addr == REG_SECOND_FB && internal_vco_mode;

   dpc_cal_seq #(
      .CAL_CYCLES (CAL_CYCLES)
   ) u_cal (
      .clk        (clk),
      .reset      (reset),
      .start      (cal_start),
      .cal_busy   (cal_busy),
      .sync_pulse (sync_event)
   );

   // RULE14: substitute calibration divider while busy
   assign second_loop_active_feedback = cal_busy ? osc_cal_q[POS_CAL_FB +: W_SECOND_FB]
                                                 : second_fb_q[POS_SECOND_FB +: W_SECOND_FB];

   ////////////////////////////////////////////////////////////////////////////
   // Readback
   logic [4:0]  rb_addr;
   logic [31:0] rb_word;
   logic        rb_reserved;
   assign rb_addr = rb_ctrl_q[POS_RB_ADDR +: W_RB_ADDR];
   // RULE17: latch level presented to framer
   assign rb_latch_level = rb_ctrl_q[POS_RB_LEVEL];
   // RULE18: reserved addresses return zero
   assign rb_reserved = (rb_addr == RB_RESERVED_A)
                     || (rb_addr >= RB_RESERVED_LO && rb_addr <= RB_RESERVED_HI);
   assign rd_addr = rb_addr;

   always_comb begin
      rb_word = 32'h0000_0000;
      if (!rb_reserved) begin
         unique case (rb_addr)
            REG_FIRST_PUMP_REF: rb_word = pump_ref_q;
            REG_SECOND_REF_FB:  rb_word = ref_fb_q;
            REG_OSC_RANGE_CAL:  rb_word = osc_cal_q;
            REG_SECOND_FB:      rb_word = second_fb_q;
            REG_READBACK_CTRL:  rb_word = rb_ctrl_q;
            // RULE19: echo readback address in register 12
            REG_READBACK_ECHO: begin
               rb_word = echo_reg_in;
               rb_word[POS_ECHO_ADDR +: W_RB_ADDR] = rb_addr;
            end
            default:            rb_word = other_reg_in;
         endcase
      end
   end

   // Registered so the framer sees a stable word
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_data  <= 32'h0000_0000;
         rd_valid <= 1'b0;
      end else begin
         rd_data  <= rb_word;
         rd_valid <= !rb_reserved;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // Calibration request and its two visible steps
   sequence s_cal_request;
      wr_ok && wr_addr == REG_SECOND_FB && internal_vco_mode;
   endsequence : s_cal_request
   sequence s_cal_run;
      sync_event ##1 cal_busy;
   endsequence : s_cal_run

   // Storage and lock
   a_lock_blocks_write: assert property ( // RULE21
      (wr_strobe && lock_q && wr_addr == REG_SECOND_FB) |=> $stable(second_fb_q))
      else $error("locked write changed register");
   a_lock_holds_bank: assert property ( // RULE21
      (wr_strobe && lock_q && wr_addr != REG_READBACK_CTRL)
      |=> $stable({pump_ref_q, ref_fb_q, osc_cal_q, second_fb_q}))
      else $error("locked write changed bank");
   a_lock_follows_bit: assert property ( // RULE21
      (wr_strobe && wr_addr == REG_READBACK_CTRL) |=> lock_q == $past(wr_data[POS_WRITE_LOCK]))
      else $error("lock bit not taken");
   a_write_stores: assert property ( // RULE22
      (wr_strobe && !lock_q && wr_addr == REG_FIRST_PUMP_REF) |=> pump_ref_q == $past(wr_data))
      else $error("unlocked write not stored");
   a_invalid_fb1_stored: assert property ( // RULE22
      (wr_ok && wr_addr == REG_SECOND_REF_FB && wr_data[POS_FIRST_FB +: W_FIRST_FB] == 14'h0000)
      |=> ref_fb_q == $past(wr_data))
      else $error("zero divider not stored");

   // Pump decode
   a_polarity: assert property ( // RULE1
      first_loop_pump_polarity == pump_ref_q[POS_PUMP_POL])
      else $error("polarity mismatch");
   a_hiz_floats: assert property ( // RULE3
      pump_ref_q[POS_PUMP_HIZ] |-> !first_loop_pump_output_en)
      else $error("pump driven in hi-z");
   a_hiz_clear_drives: assert property ( // RULE3
      !pump_ref_q[POS_PUMP_HIZ] |-> first_loop_pump_output_en)
      else $error("pump not driven");
   a_pump_current: assert property ( // RULE2
      pump_code == 2'h3 |-> first_loop_pump_ua == 11'h640)
      else $error("pump current wrong");
   a_pump_low: assert property ( // RULE2
      pump_code == 2'h0 |-> first_loop_pump_ua == 11'h064)
      else $error("pump code 0 wrong");
   a_pump_mid: assert property ( // RULE2
      pump_code == 2'h1 |-> first_loop_pump_ua == 11'h0c8)
      else $error("pump code 1 wrong");
   a_pump_high: assert property ( // RULE2
      pump_code == 2'h2 |-> first_loop_pump_ua == 11'h190)
      else $error("pump code 2 wrong");

   // Pre-divider follows the active input
   a_pre_input_two: assert property ( // RULE5
      active_input == 2'h2 |-> input_pre_ratio == 4'h1 << pump_ref_q[POS_PRE_DIV2 +: 2])
      else $error("input 2 pre-divider not applied");
   a_pre_input_one: assert property ( // RULE5
      active_input == 2'h1 |-> input_pre_ratio == 4'h1 << pump_ref_q[POS_PRE_DIV1 +: 2])
      else $error("input 1 pre-divider not applied");
   a_pre_input_zero: assert property ( // RULE4
      (active_input == 2'h0 || active_input == 2'h3)
      |-> input_pre_ratio == 4'h1 << pump_ref_q[POS_PRE_DIV0 +: 2])
      else $error("input 0 pre-divider not applied");

   // Zero and reserved codes are flagged, prescaler codes mapped
   a_ref1_zero_flag: assert property ( // RULE6
      first_loop_ref_divider == 14'h0000 |-> config_invalid)
      else $error("zero first reference not flagged");
   a_ref2_zero_flag: assert property ( // RULE7
      second_loop_ref_divider == 12'h000 |-> config_invalid)
      else $error("zero second reference not flagged");
   a_fb1_zero_flag: assert property ( // RULE9
      first_loop_feedback_divider == 14'h0000 |-> config_invalid)
      else $error("zero first feedback not flagged");
   a_fb2_zero_flag: assert property ( // RULE16
      second_fb_q[POS_SECOND_FB +: W_SECOND_FB] == 18'h00000 |-> config_invalid)
      else $error("zero second feedback not flagged");
   a_range_reserved: assert property ( // RULE10
      osc_input_freq_range == OSC_RANGE_RESERVED |-> config_invalid)
      else $error("reserved range not flagged");
   a_prescale_zero: assert property ( // RULE15
      second_fb_q[POS_PRESCALER +: 3] == 3'h0 |-> second_loop_prescale_ratio == 4'h8)
      else $error("prescaler zero not eight");
   a_prescale_two: assert property ( // RULE15
      (second_fb_q[POS_PRESCALER +: 3] inside {3'h1, 3'h2}) |-> second_loop_prescale_ratio == 4'h2)
      else $error("prescaler one or two not two");
   a_prescale_own: assert property ( // RULE15
      second_fb_q[POS_PRESCALER +: 3] >= 3'h3
      |-> second_loop_prescale_ratio == {1'b0, second_fb_q[POS_PRESCALER +: 3]})
      else $error("prescaler not own value");

   // Calibration
   a_cal_on_write: assert property ( // RULE12
      s_cal_request |=> s_cal_run)
      else $error("no calibration after write");
   a_no_cal_external: assert property ( // RULE12
      (wr_ok && wr_addr == REG_SECOND_FB && !internal_vco_mode && !cal_busy) |=> !sync_event)
      else $error("calibration without internal oscillator");
   a_sync_single: assert property ( // RULE13
      (sync_event && !cal_start) |=> !sync_event)
      else $error("sync longer than one cycle");
   a_cal_divider: assert property ( // RULE14
      cal_busy |-> second_loop_active_feedback == osc_cal_q[POS_CAL_FB +: W_SECOND_FB])
      else $error("calibration divider not used");
   a_idle_divider: assert property ( // RULE14
      !cal_busy |-> second_loop_active_feedback == second_fb_q[POS_SECOND_FB +: W_SECOND_FB])
      else $error("normal divider not used");

   // Readback
   a_echo_addr: assert property ( // RULE19
      rb_addr == REG_READBACK_ECHO |=> rd_data[POS_ECHO_ADDR +: W_RB_ADDR] == REG_READBACK_ECHO)
      else $error("register 12 echo wrong");
   a_reserved_quiet: assert property ( // RULE18
      rb_addr == RB_RESERVED_A |=> !rd_valid && rd_data == 32'h0000_0000)
      else $error("reserved readback not empty");
   a_rb_bank_word: assert property ( // RULE18
      rb_addr == REG_FIRST_PUMP_REF |=> rd_valid && rd_data == $past(pump_ref_q))
      else $error("bank readback wrong");
endmodule : dpc_regs
`default_nettype wire

// ---- test/dpc_host.sv ----
// Host controller model on the deframed configuration write port
`default_nettype none
module dpc_host (
   input  wire logic clk,
   output logic        wr_strobe,
   output logic [4:0]  wr_addr,
   output logic [31:0] wr_data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      wr_strobe = 1'b0;
      wr_addr   = 5'h00;
      wr_data   = 32'h0000_0000;
   end
   // One word per strobe, held for the whole taking cycle
   task automatic write(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      #1;
      wr_strobe = 1'b1;
      wr_addr   = a;
      wr_data   = d;
      @(posedge clk);
      #1;
      wr_strobe = 1'b0;
      // Released lines show the inverse, not a stale copy
      wr_addr   = ~a;
      wr_data   = ~d;
   endtask : write
endmodule : dpc_host
`default_nettype wire

// ---- test/dpc_regs_test.sv ----
// Self-checking bench for the divider configuration register bank
`default_nettype none
module dpc_regs_test
   import dpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CAL_N = 4;
   logic        clk, reset, internal_vco_mode, wr_strobe;
   logic [1:0]  active_input;
   logic [4:0]  wr_addr, rd_addr;
   logic [31:0] wr_data, echo_reg_in, other_reg_in, rd_data;
   logic        rd_valid, rb_latch_level, first_loop_pump_polarity, first_loop_pump_output_en;
   logic [10:0] first_loop_pump_ua;
   logic [3:0]  input_pre_ratio, second_loop_prescale_ratio;
   logic [13:0] first_loop_ref_divider, first_loop_feedback_divider;
   logic [11:0] second_loop_ref_divider;
   logic [2:0]  osc_input_freq_range;
   logic [17:0] second_loop_active_feedback;
   logic        second_loop_fast_detector, register_write_lock, cal_busy, sync_event;
   logic        config_invalid;
   int          fails = 0;
   int          compares = 0;
   int          n;
   logic [10:0] ua_tab [4] = '{11'h064, 11'h0c8, 11'h190, 11'h640};
   logic [3:0]  pre_tab [4] = '{4'h4, 4'h2, 4'h8, 4'h4};
   logic [4:0]  rb_a [6] = '{5'h1b, 5'h0c, 5'h09, 5'h10, 5'h17, 5'h05};
   logic [31:0] rb_d [6] = '{32'h000f_ffc0, 32'ha5ac_a5a5, 32'h0, 32'h0, 32'h0, 32'h1234_5678};

   dpc_host host (.clk, .wr_strobe, .wr_addr, .wr_data);
   dpc_regs #(.CAL_CYCLES(CAL_N)) dut (
      .clk, .reset, .wr_strobe, .wr_addr, .wr_data, .echo_reg_in, .other_reg_in,
      .rd_data, .rd_addr, .rd_valid, .rb_latch_level, .active_input, .internal_vco_mode,
      .first_loop_pump_polarity, .first_loop_pump_ua, .first_loop_pump_output_en,
      .input_pre_ratio, .first_loop_ref_divider, .second_loop_ref_divider,
      .first_loop_feedback_divider, .osc_input_freq_range, .second_loop_fast_detector,
      .second_loop_prescale_ratio, .second_loop_active_feedback, .register_write_lock,
      .cal_busy, .sync_event, .config_invalid);

   always #12.5 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : tick

   task automatic test_done();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   initial begin
      clk = 1'b0;
      reset = 1'b1;
      internal_vco_mode = 1'b0;
      active_input = 2'h0;
      echo_reg_in = 32'ha5a5_a5a5;
      other_reg_in = 32'h1234_5678;
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      chk(first_loop_ref_divider, 32'h1, "ref1 reset");
      chk(first_loop_pump_ua, 32'h064, "ua reset");
      chk(first_loop_pump_output_en, 32'h1, "pump on reset");
      chk({register_write_lock, config_invalid}, 32'h0, "lock/invalid reset");
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         host.write(REG_FIRST_PUMP_REF, 32'h40 | (32'(i % 4) << 26) | (32'(i / 4) * 32'h1000_0020));
         chk(first_loop_pump_polarity, 32'(i / 4), "polarity");
         chk(first_loop_pump_output_en, 32'(i < 4), "pump enable");
         if (i < 4) chk(first_loop_pump_ua, ua_tab[i], "pump current");
      end
      $display("test pump done");
      host.write(REG_FIRST_PUMP_REF, 32'h0360_0040);
      for (int j = 0; j < 4; j++) begin
         active_input = 2'(j);
         tick(1);
         chk(input_pre_ratio, pre_tab[j], "pre ratio");
      end
      $display("test prediv done");
      host.write(REG_FIRST_PUMP_REF, 32'h000f_ffc0);
      chk({config_invalid, first_loop_ref_divider}, 32'h3fff, "ref1 max");
      host.write(REG_FIRST_PUMP_REF, 32'h0);
      chk({config_invalid, first_loop_ref_divider}, 32'h4000, "ref1 zero");
      host.write(REG_FIRST_PUMP_REF, 32'h40);
      host.write(REG_SECOND_REF_FB, 32'hfff0_0000);
      chk({config_invalid, second_loop_ref_divider, first_loop_feedback_divider},
          32'h7ffc000, "fb1 zero");
      host.write(REG_SECOND_REF_FB, 32'h0003_ffc0);
      chk({config_invalid, second_loop_ref_divider, first_loop_feedback_divider},
          32'h4000fff, "ref2 zero");
      // Ratio kept above one so the doubler elsewhere may stay off
      host.write(REG_SECOND_REF_FB, 32'h0020_0040);
      chk(config_invalid, 32'h0, "dividers valid");
      $display("test dividers done");
      for (int k = 0; k < 8; k++) begin
         host.write(REG_OSC_RANGE_CAL, (32'(k) << 24) | (32'(k % 2) << 23) | 32'h20);
         chk({osc_input_freq_range, second_loop_fast_detector}, 32'(k * 2 + k % 2), "range");
         chk(config_invalid, 32'(k == 3 || k > 4), "range code");
      end
      host.write(REG_OSC_RANGE_CAL, 32'h0054_b4a0);
      $display("test range done");
      host.write(REG_SECOND_FB, 32'h0);
      chk({config_invalid, sync_event}, 32'h2, "fb2 zero");
      host.write(REG_SECOND_FB, 32'h007f_ffe0);
      chk({sync_event, cal_busy}, 32'h0, "no cal external");
      chk(second_loop_active_feedback, 32'h3ffff, "fb2 max");
      internal_vco_mode = 1'b1;
      for (int p = 0; p < 8; p++) begin
         host.write(REG_SECOND_FB, (32'(p) << 24) | 32'h0024_68a0);
         chk(second_loop_prescale_ratio, (p == 0) ? 32'h8 : (p < 3) ? 32'h2 : 32'(p), "pre2");
         chk({sync_event, cal_busy}, 32'h3, "cal start");
         chk(second_loop_active_feedback, 32'h2a5a5, "cal divider");
         n = 1;
         tick(1);
         chk(sync_event, 32'h0, "sync pulse");
         while (cal_busy === 1'b1 && n < 64) begin
            n++;
            tick(1);
         end
         chk(32'(n), 32'(CAL_N + 1), "cal length");
         if (n >= 64) test_done();
         chk(second_loop_active_feedback, 32'h12345, "fb2 after cal");
      end
      // A second write mid-run restarts the run
      host.write(REG_SECOND_FB, 32'h0024_68a0);
      host.write(REG_SECOND_FB, 32'h0024_68a0);
      chk({sync_event, cal_busy}, 32'h3, "cal restart");
      tick(CAL_N);
      chk(cal_busy, 32'h1, "restart still busy");
      tick(1);
      chk(cal_busy, 32'h0, "restart done");
      $display("test calibration done");
      host.write(REG_READBACK_CTRL, 32'h20);
      host.write(REG_FIRST_PUMP_REF, 32'h000f_ffc0);
      host.write(REG_SECOND_FB, 32'h20);
      chk({register_write_lock, first_loop_ref_divider}, 32'h4001, "locked ref1");
      chk({sync_event, second_loop_active_feedback}, 32'h12345, "locked fb2");
      host.write(REG_READBACK_CTRL, 32'h0);
      host.write(REG_FIRST_PUMP_REF, 32'h000f_ffc0);
      chk({register_write_lock, first_loop_ref_divider}, 32'h3fff, "unlocked");
      tick(CAL_N + 2);
      $display("test lock done");
      for (int r = 0; r < 6; r++) begin
         host.write(REG_READBACK_CTRL, (32'(r % 2) << 21) | (32'(rb_a[r]) << 16));
         tick(1);
         chk({rb_latch_level, rd_addr}, (32'(r % 2) << 5) | 32'(rb_a[r]), "rb addr");
         chk(rd_valid, 32'(r < 2 || r == 5), "rb valid");
         chk(rd_data, rb_d[r], "rb data");
      end
      host.write(REG_READBACK_CTRL, 32'h003f_0020);
      tick(1);
      chk(32'(rd_data[5]), 32'h1, "rb lock bit");
      host.write(REG_READBACK_CTRL, 32'h0);
      $display("test readback done");
      test_done();
   end
endmodule : dpc_regs_test
`default_nettype wire
